// ==== rrsc_far.sv ====
`timescale 1ns/1ps
// far controller: panel levels and a scan tick
module rrsc_far
    import rrsc_pkg::*;
(
    // clock
    input  wire logic   clk,
    // panel levels from the bench
    input  wire logic   key,
    input  wire logic   prot,
    input  wire logic   hold,
    input  wire logic   rdy,
    // view seen by the block
    output rrsc_target_t tgt
);
    logic [2:0] cnt = 3'h0; // eight-cycle scan keeps waits short
    // free-running scan, so ticks also come while idle; plain always keeps the
    // declaration initialiser from counting as a second driver
    always @(posedge clk)
        cnt <= cnt + 3'h1;
    // panel levels, tick once a scan
    assign tgt = '{key, prot, hold, rdy, cnt == 3'h7};
endmodule // rrsc_far

// ==== rrsc_pkg.sv ====
// shared constants and carriers for the remote run/stop control block
package rrsc_pkg;

    // register byte offsets
    localparam logic [7:0] OFS_REQ_CMD   = 8'h00; // request word 0: command
    localparam logic [7:0] OFS_REQ_SEL   = 8'h04; // request word 1: run/stop selection
    localparam logic [7:0] OFS_REQ_MODE  = 8'h08; // request word 2: execution mode
    localparam logic [7:0] OFS_REQ_CLEAR = 8'h0C; // request word 3: clear mode
    localparam logic [7:0] OFS_CTRL      = 8'h10; // start strobe
    localparam logic [7:0] OFS_RETRY     = 8'h14; // retransmission limit / count made
    localparam logic [7:0] OFS_MON_TIME  = 8'h18; // arrival monitoring time, seconds
    localparam logic [7:0] OFS_RSP_CMD   = 8'h1C; // response word 0
    localparam logic [7:0] OFS_RSP_SEL   = 8'h20; // response word 1
    localparam logic [7:0] OFS_STATUS    = 8'h24; // busy, done, running, end code
    localparam logic [7:0] OFS_IRQ_STAT  = 8'h28; // sticky events, write one to clear
    localparam logic [7:0] OFS_IRQ_MASK  = 8'h2C; // event enables

    // field positions
    localparam int CTRL_GO_BIT     = 0;
    localparam int ST_BUSY_BIT     = 0;
    localparam int ST_DONE_BIT     = 1;
    localparam int ST_ERR_BIT      = 2;
    localparam int ST_RUNNING_BIT  = 3;
    localparam int ST_REMOTE_BIT   = 4;
    localparam int ST_CODE_LSB     = 8;
    localparam int IRQ_DONE_BIT    = 0;
    localparam int IRQ_ABN_BIT     = 1;

    // request and response codes
    localparam logic [15:0] CMD_REMOTE    = 16'h0010;
    localparam logic [15:0] RSP_REMOTE    = 16'h0090;
    localparam logic [15:0] SEL_RUN       = 16'h0001;
    localparam logic [15:0] SEL_STOP      = 16'h0002;
    localparam logic [15:0] MODE_NOFORCE  = 16'h0001;
    localparam logic [15:0] MODE_FORCE    = 16'h0003;
    localparam logic [15:0] CLR_NONE      = 16'h0000;
    localparam logic [15:0] CLR_NO_LATCH  = 16'h0001;
    localparam logic [15:0] CLR_ALL       = 16'h0002;

    // end codes reported in the status register
    localparam logic [7:0] END_OK        = 8'h00;
    localparam logic [7:0] END_PROTECT   = 8'h01;
    localparam logic [7:0] END_FORMAT    = 8'h02;
    localparam logic [7:0] END_HELD      = 8'h03;
    localparam logic [7:0] END_TIMEOUT   = 8'h04;

    // reset values
    localparam logic [3:0]  RETRY_RST    = 4'h0;
    localparam logic [14:0] MON_RST      = 15'h0000;
    localparam logic [1:0]  MASK_RST     = 2'h0;

    // timing
    localparam int CLK_PERIOD_NS   = 20;            // 50 MHz
    localparam int SECOND_NS       = 1_000_000_000;
    localparam int SEC_CYCLES_DEF  = SECOND_NS / CLK_PERIOD_NS;
    localparam logic [14:0] MON_DEFAULT_S = 15'd10; // used when monitoring time is zero
    localparam logic [14:0] MON_MAX_S     = 15'd32767;
    localparam int RETRY_MAX       = 15;

    // sequencer states
    typedef enum logic [2:0] {S_IDLE, S_WAIT, S_EXEC, S_ARM, S_DONE} rrsc_fsm_t;

    // apb request from the bus master
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } rrsc_apb_req_t;

    // apb answer to the bus master
    typedef struct packed {
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
    } rrsc_apb_rsp_t;

    // state of the controller being steered
    typedef struct packed {
        logic key_run;               // front key switch at run
        logic system_protect_switch; // protection on
        logic ext_hold;              // another station holds remote stop/pause
        logic target_ready;          // target can take the request now
        logic scan_tick;             // end of a program scan, one cycle
    } rrsc_target_t;

endpackage

// ==== rrsc_top.sv ====
// Decided for this implementation: register access over APB and the address map.
`timescale 1ns/1ps
// Overview of operation
// RULE_01: request words: 0010H, then 0001H/0002H
// RULE_02: run mode 0001H normal, 0003H forced
// RULE_03: stop request carries mode 0003H
// RULE_04: clear mode 0000H/0001H/0002H on run
// RULE_05: stop request carries clear mode 0000H
// RULE_06: after clear, start from initial values
// RULE_07: response echoes 0090H and selection
// RULE_08: protection refuses every request abnormally
// RULE_09: key at stop keeps target stopped
// RULE_10: reset discards remote run/stop state
// RULE_11: unforced run on held station fails
// RULE_12: retry count reloaded before each start
// RULE_13: completion bit high exactly one scan
// RULE_14: next bit marks abnormal end
// RULE_15: local module picked by head number
// RULE_16: write needs dummy response area
// RULE_17: retransmit after monitoring time, default 10s
// RULE_18: retries 0..15, count made written back
module rrsc_top
    import rrsc_pkg::*;
#(
    parameter int unsigned SEC_CYCLES = SEC_CYCLES_DEF // clock cycles per second
)(
    // clock and reset
    input  wire logic          clk,
    input  wire logic          srst,
    // register bus
    input  wire rrsc_apb_req_t apb_req,
    output rrsc_apb_rsp_t      apb_rsp,
    // controller being steered
    input  wire rrsc_target_t  tgt,
    output logic               running,
    output logic               mem_clear_pulse,
    output logic [1:0]         mem_clear_mode,
    output logic               init_values_pulse,
    // completion pair and interrupt
    output logic               done,
    output logic               done_err,
    output logic               irq
);

    localparam int PRE_W = $clog2(SEC_CYCLES);

    // refuse a prescaler that cannot count a second
    if (SEC_CYCLES < 2) begin : g_chk
        $error("SEC_CYCLES must be at least 2");
    end

    // whole module state
    typedef struct packed {
        rrsc_fsm_t        fsm;         // sequencer
        logic [15:0]      req_cmd;     // request word 0
        logic [15:0]      req_sel;     // request word 1
        logic [15:0]      req_mode;    // request word 2
        logic [15:0]      req_clear;   // request word 3
        logic [3:0]       retry_word;  // limit in, count made out
        logic [3:0]       retries;     // retransmissions so far
        logic [14:0]      mon_time;    // monitoring time setting
        logic [PRE_W-1:0] sec_pre;     // one-second prescaler
        logic [14:0]      sec_cnt;     // seconds waited
        logic [15:0]      rsp_cmd;     // response word 0
        logic [15:0]      rsp_sel;     // response word 1
        logic [7:0]       end_code;    // last end status
        logic             remote_valid; // a remote state applies
        logic             remote_run;   // that state is run
        logic             running;      // target operating
        logic             done;         // completion bit
        logic             done_err;     // abnormal end bit
        logic             clr_pulse;    // memory clear strobe
        logic [1:0]       clr_mode;     // memory clear kind
        logic             init_pulse;   // load initial values
        logic [1:0]       irq_stat;     // sticky events
        logic [1:0]       irq_mask;     // event enables
        logic [31:0]      prdata;       // read data
        logic             pslverr;      // unmapped access
    } rrsc_state_t;

    rrsc_state_t st_reg;  // registered state
    rrsc_state_t st_next; // next state

    // decoded request fields
    logic        is_run;     // run selected
    logic        is_stop;    // stop selected
    logic        fmt_ok;     // request block well formed
    logic [14:0] mon_limit;  // effective seconds
    logic        wr_acc;     // write in access phase
    logic        rd_setup;   // setup phase of any transfer
    logic        mapped;     // address decodes
    logic        sec_wrap;   // a second elapsed
    logic [1:0]  irq_evt;    // events this cycle
    logic [1:0]  irq_clr;    // software clears

    // request decode, the requester owns the encoding
    always_comb
    begin
        is_run  = (st_reg.req_sel == SEL_RUN);  // [RULE_01]
        is_stop = (st_reg.req_sel == SEL_STOP); // [RULE_01]
        // run takes either mode and a clear kind; stop takes fixed words
        fmt_ok  = (st_reg.req_cmd == CMD_REMOTE)
                  && ((is_run && (st_reg.req_mode == MODE_NOFORCE // [RULE_02]
                                  || st_reg.req_mode == MODE_FORCE)
                       && st_reg.req_clear <= CLR_ALL)            // [RULE_04]
                      || (is_stop && st_reg.req_mode == MODE_FORCE // [RULE_03]
                          && st_reg.req_clear == CLR_NONE));      // [RULE_05]
        // zero selects the default time
        mon_limit = (st_reg.mon_time == 15'h0000) ? MON_DEFAULT_S : st_reg.mon_time; // [RULE_17]
    end

    // bus decode; pready is always high so every access ends in one access cycle
    always_comb
    begin
        wr_acc   = apb_req.psel && apb_req.penable && apb_req.pwrite;
        rd_setup = apb_req.psel && !apb_req.penable;
        case (apb_req.paddr)
            OFS_REQ_CMD, OFS_REQ_SEL, OFS_REQ_MODE, OFS_REQ_CLEAR, OFS_CTRL,
            OFS_RETRY, OFS_MON_TIME, OFS_RSP_CMD, OFS_RSP_SEL, OFS_STATUS,
            OFS_IRQ_STAT, OFS_IRQ_MASK: mapped = 1'b1;
            default:                    mapped = 1'b0;
        endcase
    end

    // next state
    always_comb
    begin
        st_next  = st_reg;
        sec_wrap = (st_reg.sec_pre == PRE_W'(SEC_CYCLES - 1));
        irq_evt  = 2'h0;
        irq_clr  = 2'h0;
        // strobes last one cycle
        st_next.clr_pulse  = 1'b0;
        st_next.init_pulse = st_reg.clr_pulse; // initial values follow the clear [RULE_06]

        // register writes; request words are frozen while busy
        if (wr_acc)
        begin
            case (apb_req.paddr)
                OFS_REQ_CMD:   if (st_reg.fsm == S_IDLE) st_next.req_cmd   = apb_req.pwdata[15:0];
                OFS_REQ_SEL:   if (st_reg.fsm == S_IDLE) st_next.req_sel   = apb_req.pwdata[15:0];
                OFS_REQ_MODE:  if (st_reg.fsm == S_IDLE) st_next.req_mode  = apb_req.pwdata[15:0];
                OFS_REQ_CLEAR: if (st_reg.fsm == S_IDLE) st_next.req_clear = apb_req.pwdata[15:0];
                // software reloads the limit before each start [RULE_12]
                OFS_RETRY:     if (st_reg.fsm == S_IDLE) st_next.retry_word = apb_req.pwdata[3:0];
                OFS_MON_TIME:  if (st_reg.fsm == S_IDLE) st_next.mon_time  = apb_req.pwdata[14:0];
                OFS_IRQ_STAT:  irq_clr = apb_req.pwdata[1:0];
                OFS_IRQ_MASK:  st_next.irq_mask = apb_req.pwdata[1:0];
                default:       ;
            endcase
        end

        // sequencer
        case (st_reg.fsm)
            S_IDLE:
            begin
                // a start while busy is simply ignored
                if (wr_acc && apb_req.paddr == OFS_CTRL && apb_req.pwdata[CTRL_GO_BIT])
                begin
                    st_next.fsm     = S_WAIT;
                    st_next.retries = 4'h0;
                    st_next.sec_pre = '0;
                    st_next.sec_cnt = 15'h0000;
                end
            end
            S_WAIT:
            begin
                if (tgt.target_ready)
                    st_next.fsm = S_EXEC;
                else
                begin
                    st_next.sec_pre = sec_wrap ? '0 : st_reg.sec_pre + 1'b1;
                    if (sec_wrap)
                    begin
                        st_next.sec_cnt = st_reg.sec_cnt + 15'd1;
                        // monitoring time ran out: resend or give up [RULE_17]
                        if (st_reg.sec_cnt + 15'd1 >= mon_limit)
                        begin
                            st_next.sec_cnt = 15'h0000;
                            if (st_reg.retries < st_reg.retry_word) // [RULE_18]
                                st_next.retries = st_reg.retries + 4'd1;
                            else
                            begin
                                st_next.end_code = END_TIMEOUT;
                                st_next.fsm      = S_ARM;
                            end
                        end
                    end
                end
            end
            S_EXEC:
            begin
                st_next.fsm = S_ARM;
                // response carries its code and echoes the selection [RULE_07]
                st_next.rsp_cmd = RSP_REMOTE;
                st_next.rsp_sel = st_reg.req_sel;
                if (tgt.system_protect_switch)
                    st_next.end_code = END_PROTECT; // [RULE_08]
                else if (!fmt_ok)
                    st_next.end_code = END_FORMAT;
                else if (is_run && st_reg.req_mode == MODE_NOFORCE && tgt.ext_hold)
                    st_next.end_code = END_HELD;    // held station stays put [RULE_11]
                else
                begin
                    st_next.end_code     = END_OK;
                    st_next.remote_valid = 1'b1;
                    st_next.remote_run   = is_run;
                    if (is_run)
                    begin
                        // clear first; initial values load the cycle after [RULE_04]
                        st_next.clr_pulse = 1'b1;
                        st_next.clr_mode  = st_reg.req_clear[1:0];
                    end
                end
            end
            S_ARM:
            begin
                // completion rises at a scan boundary [RULE_13]
                if (tgt.scan_tick)
                begin
                    st_next.fsm        = S_DONE;
                    st_next.done       = 1'b1;
                    st_next.done_err   = (st_reg.end_code != END_OK); // [RULE_14]
                    st_next.retry_word = st_reg.retries;              // [RULE_18]
                    irq_evt[IRQ_DONE_BIT] = 1'b1;
                    irq_evt[IRQ_ABN_BIT]  = (st_reg.end_code != END_OK);
                end
            end
            S_DONE:
            begin
                // and falls at the next one, one scan later [RULE_13]
                if (tgt.scan_tick)
                begin
                    st_next.fsm      = S_IDLE;
                    st_next.done     = 1'b0;
                    st_next.done_err = 1'b0;
                end
            end
            default: st_next.fsm = S_IDLE;
        endcase

        // key at stop wins over any remote run [RULE_09]
        st_next.running = tgt.key_run && (!st_next.remote_valid || st_next.remote_run);

        // a new event beats a clear in the same cycle
        st_next.irq_stat = (st_reg.irq_stat & ~irq_clr) | irq_evt;

        // read data captured in the setup phase, answered in the access phase
        st_next.pslverr = 1'b0;
        if (rd_setup)
        begin
            st_next.pslverr = !mapped;
            case (apb_req.paddr)
                OFS_REQ_CMD:   st_next.prdata = {16'h0000, st_reg.req_cmd};
                OFS_REQ_SEL:   st_next.prdata = {16'h0000, st_reg.req_sel};
                OFS_REQ_MODE:  st_next.prdata = {16'h0000, st_reg.req_mode};
                OFS_REQ_CLEAR: st_next.prdata = {16'h0000, st_reg.req_clear};
                OFS_RETRY:     st_next.prdata = {28'h0000000, st_reg.retry_word};
                OFS_MON_TIME:  st_next.prdata = {17'h00000, st_reg.mon_time};
                OFS_RSP_CMD:   st_next.prdata = {16'h0000, st_reg.rsp_cmd};
                OFS_RSP_SEL:   st_next.prdata = {16'h0000, st_reg.rsp_sel};
                OFS_STATUS:
                begin
                    st_next.prdata = 32'h00000000;
                    st_next.prdata[ST_BUSY_BIT]    = (st_reg.fsm != S_IDLE);
                    st_next.prdata[ST_DONE_BIT]    = st_reg.done;
                    st_next.prdata[ST_ERR_BIT]     = st_reg.done_err;
                    st_next.prdata[ST_RUNNING_BIT] = st_reg.running;
                    st_next.prdata[ST_REMOTE_BIT]  = st_reg.remote_valid;
                    st_next.prdata[ST_CODE_LSB +: 8] = st_reg.end_code;
                end
                OFS_IRQ_STAT:  st_next.prdata = {30'h00000000, st_reg.irq_stat};
                OFS_IRQ_MASK:  st_next.prdata = {30'h00000000, st_reg.irq_mask};
                default:       st_next.prdata = 32'h00000000;
            endcase
        end
    end

    // state register; reset drops any remote state [RULE_10]
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            st_reg            <= '0;
            st_reg.fsm        <= S_IDLE;
            st_reg.retry_word <= RETRY_RST;
            st_reg.mon_time   <= MON_RST;
            st_reg.irq_mask   <= MASK_RST;
        end
        else
            st_reg <= st_next;
    end

    // outputs
    assign apb_rsp.prdata    = st_reg.prdata;
    assign apb_rsp.pready    = 1'b1;
    assign apb_rsp.pslverr   = st_reg.pslverr && apb_req.psel && apb_req.penable;
    assign running           = st_reg.running;
    assign mem_clear_pulse   = st_reg.clr_pulse;
    assign mem_clear_mode    = st_reg.clr_mode;
    assign init_values_pulse = st_reg.init_pulse;
    assign done              = st_reg.done;
    assign done_err          = st_reg.done_err;
    assign irq               = |(st_reg.irq_stat & st_reg.irq_mask);

    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);

    // completion rises only right after a scan boundary
    property p_done_rise;
        $rose(done) |-> $past(tgt.scan_tick);
    endproperty
    a_done_rise: assert property (p_done_rise) else $error("done rose off a scan boundary"); // [RULE_13]

    // completion holds through the scan and drops at its end
    property p_done_fall;
        done && !tgt.scan_tick |=> done;
    endproperty
    a_done_fall: assert property (p_done_fall) else $error("done dropped mid scan"); // [RULE_13]

    // abnormal bit only with completion and matching end code
    property p_err_pair;
        done |-> (done_err == (st_reg.end_code != END_OK));
    endproperty
    a_err_pair: assert property (p_err_pair) else $error("abnormal bit wrong"); // [RULE_14]

    // protection always ends abnormally
    property p_protect;
        st_reg.fsm == S_EXEC && tgt.system_protect_switch
            |=> st_reg.end_code == END_PROTECT ##[1:1000] $rose(done_err);
    endproperty
    a_protect: assert property (p_protect) else $error("protected request not refused"); // [RULE_08]

    // key at stop forces stopped
    property p_key_stop;
        !tgt.key_run |=> !running;
    endproperty
    a_key_stop: assert property (p_key_stop) else $error("running with key at stop"); // [RULE_09]

    // reset leaves no remote state and no completion bit
    property p_reset_clear;
        @(posedge clk) disable iff (1'b0) srst |=> !st_reg.remote_valid && !done;
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("remote state kept over reset"); // [RULE_10]

    // unforced run on a held station ends abnormally with no remote change
    property p_held;
        st_reg.fsm == S_EXEC && !tgt.system_protect_switch && fmt_ok && is_run
            && st_reg.req_mode == MODE_NOFORCE && tgt.ext_hold
            |=> st_reg.end_code == END_HELD && $stable(st_reg.remote_run);
    endproperty
    a_held: assert property (p_held) else $error("held station not refused"); // [RULE_11]

    // clear strobe is followed by initial value load
    property p_init_after_clear;
        mem_clear_pulse |-> mem_clear_mode <= 2'd2 ##1 init_values_pulse;
    endproperty
    a_init_after_clear: assert property (p_init_after_clear) else $error("no init after clear"); // [RULE_06]

    // response echoes the selection; a timed-out request got no answer, last one stands
    property p_echo;
        $rose(done) |-> st_reg.end_code == END_TIMEOUT
            || (st_reg.rsp_cmd == RSP_REMOTE && st_reg.rsp_sel == st_reg.req_sel);
    endproperty
    a_echo: assert property (p_echo) else $error("response not echoed"); // [RULE_07]

    // retransmissions never pass the limit
    property p_retry_bound;
        st_reg.fsm == S_WAIT |-> st_reg.retries <= st_reg.retry_word;
    endproperty
    a_retry_bound: assert property (p_retry_bound) else $error("too many retransmissions"); // [RULE_18]

endmodule // rrsc_top

// ==== rrsc_top_tb_top.sv ====
`timescale 1ns/1ps
// self-checking bench for the remote run/stop block
module rrsc_top_tb_top import rrsc_pkg::*;;
    logic          clk = 1'h0;   // 50 MHz
    logic          srst = 1'h1;  // sync reset
    rrsc_apb_req_t apb_req = '0; // bus request
    rrsc_apb_rsp_t apb_rsp;      // bus answer
    rrsc_target_t  tgt;          // far view
    logic          key = 1'h1;   // panel levels
    logic          prot = 1'h0;
    logic          hold = 1'h0;
    logic          rdy = 1'h1;
    logic          running, clr_p, init_p, done, done_err, irq;
    logic [1:0]    clr_mode;     // clear kind
    logic [1:0]    mask = 2'h0;  // irq mask mirror
    logic [31:0]   q;            // read data
    logic          e;            // slave error
    int            err_total = 0, compares = 0, seed = 11, rv = 0, rr = 0;
    int            rc = 0, rs = 0; // expected response words

    // short second so timeouts fit the run
    rrsc_top #(.SEC_CYCLES(4)) dut (.clk(clk), .srst(srst), .apb_req(apb_req),
        .apb_rsp(apb_rsp), .tgt(tgt), .running(running), .mem_clear_pulse(clr_p),
        .mem_clear_mode(clr_mode), .init_values_pulse(init_p), .done(done),
        .done_err(done_err), .irq(irq));
    rrsc_far far (.clk(clk), .key(key), .prot(prot), .hold(hold), .rdy(rdy), .tgt(tgt));

    // clock
    initial
        forever #10 clk = ~clk;

    // compare and count
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp)
        begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // verdict and end of run
    task automatic conclude();
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // one apb transfer; idle edge after it avoids double drive
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        apb_req <= '{1'h1, 1'h0, w, a, d};
        @(posedge clk);
        apb_req.penable <= 1'h1;
        do
        begin
            @(posedge clk);
            n++;
        end while (apb_rsp.pready !== 1'h1 && n < 50);
        q = apb_rsp.prdata;
        e = apb_rsp.pslverr;
        apb_req.psel <= 1'h0;
        apb_req.penable <= 1'h0;
        @(posedge clk);
        if (n == 50)
        begin
            err_total++;
            conclude();
        end
    endtask

    // reference end code; no response while target is not ready
    function automatic int exp_code(int sel, int mode, int clr);
        if (!rdy)
            return 4;
        if (prot)
            return 1;
        if (sel == 1 && (mode == 1 || mode == 3) && clr <= 2 || sel == 2 && mode == 3 && clr == 0)
            return (sel == 1 && mode == 1 && hold) ? 0 + 3 : 0;
        return 2;
    endfunction

    // full request, completion and response checks
    task automatic req(input int sel, input int mode, input int clr, input int rty);
        int n;
        int pulses;
        int code;
        n = 0;
        pulses = 0;
        apb(1'h1, OFS_REQ_CMD, CMD_REMOTE);
        apb(1'h1, OFS_REQ_SEL, sel);
        apb(1'h1, OFS_REQ_MODE, mode);
        apb(1'h1, OFS_REQ_CLEAR, clr);
        apb(1'h1, OFS_RETRY, rty);
        apb(1'h1, OFS_CTRL, 32'h1);
        while (done !== 1'h1 && n < 500)
        begin
            @(posedge clk);
            n++;
            if (clr_p === 1'h1)
            begin
                pulses++;
                chk("clear mode", clr_mode, clr);
                @(posedge clk);
                chk("init pulse", init_p, 1'h1);
            end
        end
        if (n == 500)
        begin
            err_total++;
            conclude();
        end
        code = exp_code(sel, mode, clr);
        // no answer arrives on a timeout, so the last response stands
        if (code != 4)
        begin
            rc = RSP_REMOTE;
            rs = sel;
        end
        chk("error bit", done_err, code != 0);
        n = 0;
        while (done === 1'h1 && n < 20)
        begin
            @(posedge clk);
            n++;
        end
        chk("done length", n, 32'h8);
        if (n == 20)
        begin
            err_total++;
            conclude();
        end
        if (code == 0)
        begin
            rv = 1;
            rr = (sel == 1);
        end
        chk("clear pulses", pulses, code == 0 && sel == 1);
        chk("running", running, key & (!rv | rr));
        apb(1'h0, OFS_RSP_CMD, 32'h0);
        chk("rsp cmd", q, rc);
        apb(1'h0, OFS_RSP_SEL, 32'h0);
        chk("rsp sel", q, rs);
        apb(1'h0, OFS_STATUS, 32'h0);
        chk("end code", q[15:8], code);
        chk("irq", irq, (mask & {code != 0, 1'h1}) != 0);
        apb(1'h0, OFS_IRQ_STAT, 32'h0);
        chk("irq stat", q, {code != 0, 1'h1});
        apb(1'h1, OFS_IRQ_STAT, 32'h3);
        chk("irq clear", irq, 1'h0);
    endtask

    // main sequence
    initial
    begin
        repeat (5) @(posedge clk);
        srst <= 1'h0;
        @(posedge clk);
        apb(1'h0, OFS_IRQ_MASK, 32'h0);
        chk("mask rst", q, MASK_RST);
        apb(1'h0, 8'h30, 32'h0);
        chk("unmapped err", e, 1'h1);
        chk("unmapped data", q, 32'h0);
        $display("test registers finished");
        req(1, 1, $unsigned($random(seed)) % 3, 0);
        apb(1'h1, OFS_IRQ_MASK, 32'h3);
        mask = 2'h3;
        for (int i = 0; i < 3; i++)
            req(1, 3, i, 0);
        req(2, 3, 0, 0);
        $display("test run and stop finished");
        hold <= 1'h1;
        req(1, 1, 0, 0);
        req(1, 3, 0, 0);
        hold <= 1'h0;
        req(2, 1, 0, 0);
        req(1, 2, 0, 0);
        req(1, 1, 3, 0);
        prot <= 1'h1;
        req(1, 3, 0, 0);
        req(2, 3, 0, 0);
        prot <= 1'h0;
        $display("test refusals finished");
        key <= 1'h0;
        req(1, 3, 0, 0);
        key <= 1'h1;
        req(2, 3, 0, 0);
        srst <= 1'h1;
        repeat (2) @(posedge clk);
        srst <= 1'h0;
        repeat (2) @(posedge clk);
        rv = 0;
        rc = 0;
        rs = 0;
        mask = 2'h0;
        chk("run after rst", running, 1'h1);
        $display("test key and reset finished");
        rdy <= 1'h0;
        apb(1'h1, OFS_MON_TIME, 32'h1);
        req(1, 1, 0, 1);
        apb(1'h0, OFS_RETRY, 32'h0);
        chk("retries made", q, 32'h1);
        apb(1'h1, OFS_MON_TIME, 32'h0);
        req(2, 3, 0, 0);
        $display("test timeout finished");
        conclude();
    end
endmodule // rrsc_top_tb_top
